// ---- inc/tcou_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the timer compare unit
`ifndef TCOU_DEFINES_SVH
`define TCOU_DEFINES_SVH

`define TCOU_OFF_CTRL     12'h000
`define TCOU_OFF_COUNT    12'h004
`define TCOU_OFF_COMPARE  12'h008
`define TCOU_OFF_FLAGS    12'h00C
`define TCOU_OFF_PORT     12'h010

`define TCOU_CTRL_TICKEN  0
`define TCOU_CTRL_WGM_LO  1
`define TCOU_CTRL_WGM_HI  2
`define TCOU_CTRL_COM_LO  3
`define TCOU_CTRL_COM_HI  4
`define TCOU_CTRL_FORCE   5
`define TCOU_CTRL_DIV_LO  8
`define TCOU_CTRL_DIV_HI  15

`define TCOU_FLAG_OVF     0
`define TCOU_FLAG_CMP     1

`define TCOU_PORT_OUT     0
`define TCOU_PORT_DIR     1
`define TCOU_PORT_STATE   2

`define TCOU_MODE_NORMAL  2'h0
`define TCOU_MODE_CTC     2'h2
`define TCOU_COUNT_MAX    8'hFF
`define TCOU_COUNT_BOTTOM 8'h00
`define TCOU_RST_BYTE     8'h00
`define TCOU_RST_STATE    1'b0
`define TCOU_RESP_OKAY    2'h0
`define TCOU_RESP_SLVERR  2'h2

`endif

// ---- inc/tcou_pkg.sv ----
// Types of the timer compare output unit
package tcou_pkg;

    // Output action on a compare match
    typedef enum logic [1:0] {
        TCOU_ACT_NONE   = 2'h0,
        TCOU_ACT_TOGGLE = 2'h1,
        TCOU_ACT_CLEAR  = 2'h2,
        TCOU_ACT_SET    = 2'h3
    } tcou_action_t;

    // Control fields written by software
    typedef struct packed {
        logic         tickEnable;
        logic [1:0]   waveModeSelect;
        tcou_action_t outputActionSelect;
        logic [7:0]   tickDivide;
    } tcou_ctrl_t;

    // Pin of the general port that the compare output may override
    typedef struct packed {
        logic portOut;
        logic pinDirectionBit;
    } tcou_port_t;

    // Bus write states
    typedef enum logic [2:0] {
        TCOU_WR_IDLE = 3'b001,
        TCOU_WR_DO   = 3'b010,
        TCOU_WR_RESP = 3'b100
    } tcou_wstate_t;

endpackage

// ---- design/tcou_tick_div.sv ----
// Divider that makes the one-cycle timer clock enable
`timescale 1ns/1ps
`include "tcou_defines.svh"

module tcou_tick_div (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       enable,
    input  wire logic [7:0] divide,
    output logic            tick
);
    import tcou_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_tick;

    // Tick once every divide+1 clocks; stopped when disabled
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!enable) begin
            next_count = `TCOU_RST_BYTE;
        end else if (count >= divide) begin
            next_count = `TCOU_RST_BYTE;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= `TCOU_RST_BYTE;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

// ---- design/tcou_pin_mux.sv ----
// Port override: compare output replaces the port value when an action is selected
`timescale 1ns/1ps
`include "tcou_defines.svh"

module tcou_pin_mux (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  tcou_pkg::tcou_port_t   port,
    input  tcou_pkg::tcou_action_t action,
    input  wire logic              compareOutputState,
    output logic                   pinOut,
    output logic                   pinOe
);
    import tcou_pkg::*;

    logic next_pinOut;
    logic next_pinOe;

    // Override ignores the wave mode entirely
    always_comb begin
        next_pinOut = (action != TCOU_ACT_NONE) ? compareOutputState : port.portOut;
        next_pinOe  = port.pinDirectionBit;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end else begin
            pinOut <= next_pinOut;
            pinOe  <= next_pinOe;
        end
    end

    property p_dir_follows;
        @(posedge clk) disable iff (!arst_n) 1'b1 |=> pinOe == $past(port.pinDirectionBit);
    endproperty
    a_dir_follows : assert property (p_dir_follows)
        else $error("pin enable does not follow direction bit");
endmodule

// ---- design/tcou_top.sv ----
// Timer compare output unit: counter, compare, output state and AXI4-Lite registers
// Notes on behaviour
// - Counter write blocks compares next tick
// - Writing counter equal compare gives no match
// - Output state kept across mode change
// - Action select unbuffered, applies next match
// - Reset clears output state
// - Nonzero action overrides port value
// - Direction bit still controls pin
// - Override independent of wave mode
// - Action zero leaves state unchanged
// - Force strobe applies action at once while wave mode bit 0 is clear
// - Counting depends only on wave mode
// - Action sets, clears or toggles state
// - Mode zero increments and wraps
// - Overflow flag set as counter wraps from FF
// - Normal mode accepts counter writes anytime
// - Mode two clears at compare value
// - Match sets compare flag next clock while wave mode bit 0 is clear
// - Force leaves flag and counter alone
// - Counter write beats count and clear
`timescale 1ns/1ps
`include "tcou_defines.svh"

module tcou_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        overflowAck,
    input  wire logic        compareAck,
    output logic             pinOut,
    output logic             pinOe
);
    import tcou_pkg::*;

    tcou_ctrl_t   ctrl;
    tcou_port_t   port;
    logic [7:0]   counterValue;
    logic [7:0]   compareValue;
    logic         compareOutputState;
    logic         overflowFlag;
    logic         compareFlag;
    logic         blockNext;
    logic         tick;
    tcou_wstate_t wstate;
    logic [11:0]  waddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         haveAw;
    logic         haveW;

    tcou_ctrl_t   next_ctrl;
    tcou_port_t   next_port;
    logic [7:0]   next_counterValue;
    logic [7:0]   next_compareValue;
    logic         next_compareOutputState;
    logic         next_overflowFlag;
    logic         next_compareFlag;
    logic         next_blockNext;
    tcou_wstate_t next_wstate;
    logic [11:0]  next_waddr;
    logic [31:0]  next_wdata;
    logic [3:0]   next_wstrb;
    logic         next_haveAw;
    logic         next_haveW;
    logic         next_rvalid;
    logic [31:0]  next_rdata;
    logic [1:0]   next_rresp;

    logic         doWrite;
    logic         wrCount;
    logic         wrCtrl;
    logic         forceStrobe;
    logic         match;
    logic         wordOk;
    tcou_action_t actSel;

    tcou_tick_div u_div (
        .clk    (clk),
        .arst_n (arst_n),
        .enable (ctrl.tickEnable),
        .divide (ctrl.tickDivide),
        .tick   (tick)
    );

    tcou_pin_mux u_mux (
        .clk                (clk),
        .arst_n             (arst_n),
        .port               (port),
        .action             (ctrl.outputActionSelect),
        .compareOutputState (compareOutputState),
        .pinOut             (pinOut),
        .pinOe              (pinOe)
    );

    // Write channel: takes address and data in either order, then answers
    assign s_axi_awready = (wstate == TCOU_WR_IDLE) && !haveAw;
    assign s_axi_wready  = (wstate == TCOU_WR_IDLE) && !haveW;
    assign s_axi_bvalid  = (wstate == TCOU_WR_RESP);
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = (wstate == TCOU_WR_DO);
    assign wordOk        = (waddr[1:0] == 2'h0) && (waddr <= `TCOU_OFF_PORT);
    assign wrCount       = doWrite && wordOk && (waddr == `TCOU_OFF_COUNT) && wstrb[0];
    assign wrCtrl        = doWrite && wordOk && (waddr == `TCOU_OFF_CTRL) && wstrb[0];
    assign forceStrobe   = wrCtrl && wdata[`TCOU_CTRL_FORCE] && !ctrl.waveModeSelect[0];
    // A force written with a new action uses that action at once, not the old one
    assign actSel        = forceStrobe ? tcou_action_t'(wdata[`TCOU_CTRL_COM_HI:`TCOU_CTRL_COM_LO])
                                       : ctrl.outputActionSelect;
    // Match is only honoured on a tick not blocked by a recent counter write
    assign match         = tick && !blockNext && (counterValue == compareValue);

    always_comb begin
        next_wstate = wstate;
        next_waddr  = waddr;
        next_wdata  = wdata;
        next_wstrb  = wstrb;
        next_haveAw = haveAw;
        next_haveW  = haveW;
        s_axi_bresp = wordOk ? `TCOU_RESP_OKAY : `TCOU_RESP_SLVERR;
        case (wstate)
            TCOU_WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    next_waddr  = s_axi_awaddr;
                    next_haveAw = 1'b1;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    next_wdata = s_axi_wdata;
                    next_wstrb = s_axi_wstrb;
                    next_haveW = 1'b1;
                end
                if (next_haveAw && next_haveW) begin
                    next_wstate = TCOU_WR_DO;
                end
            end
            TCOU_WR_DO: begin
                next_wstate = TCOU_WR_RESP;
            end
            TCOU_WR_RESP: begin
                if (s_axi_bready) begin
                    next_wstate = TCOU_WR_IDLE;
                    next_haveAw = 1'b0;
                    next_haveW  = 1'b0;
                end
            end
            default: begin
                next_wstate = TCOU_WR_IDLE;
            end
        endcase
    end

    // Registers, counter, flags and compare output state
    always_comb begin
        next_ctrl               = ctrl;
        next_port               = port;
        next_compareValue       = compareValue;
        next_counterValue       = counterValue;
        next_compareOutputState = compareOutputState;
        next_overflowFlag       = overflowFlag;
        next_compareFlag        = compareFlag;
        next_blockNext          = blockNext;
        // Counting follows only the wave mode, and only on ticks; a tick ends the write block
        if (tick) begin
            next_blockNext = 1'b0;
            if (ctrl.waveModeSelect == `TCOU_MODE_CTC && counterValue == compareValue) begin
                next_counterValue = `TCOU_COUNT_BOTTOM;
            end else begin
                next_counterValue = counterValue + 8'h01;
            end
            if (counterValue == `TCOU_COUNT_MAX) begin
                next_overflowFlag = 1'b1;
            end
        end
        // Compare match drives the output state through the action select
        if (match && !ctrl.waveModeSelect[0]) begin
            next_compareFlag = 1'b1;
        end
        if ((match || forceStrobe) && !ctrl.waveModeSelect[0]) begin
            case (actSel)
                TCOU_ACT_TOGGLE: next_compareOutputState = !compareOutputState;
                TCOU_ACT_CLEAR:  next_compareOutputState = 1'b0;
                TCOU_ACT_SET:    next_compareOutputState = 1'b1;
                default:         next_compareOutputState = compareOutputState;
            endcase
        end
        if (doWrite && wordOk && wstrb[0]) begin
            case (waddr)
                `TCOU_OFF_CTRL: begin
                    next_ctrl.tickEnable         = wdata[`TCOU_CTRL_TICKEN];
                    next_ctrl.waveModeSelect     = wdata[`TCOU_CTRL_WGM_HI:`TCOU_CTRL_WGM_LO];
                    next_ctrl.outputActionSelect =
                        tcou_action_t'(wdata[`TCOU_CTRL_COM_HI:`TCOU_CTRL_COM_LO]);
                end
                `TCOU_OFF_COUNT: begin
                    next_counterValue = wdata[7:0];
                    next_blockNext    = 1'b1;
                end
                `TCOU_OFF_COMPARE: next_compareValue = wdata[7:0];
                `TCOU_OFF_FLAGS: begin
                    // A flag set in this cycle survives the clear
                    if (wdata[`TCOU_FLAG_OVF] && !(tick && counterValue == `TCOU_COUNT_MAX)) begin
                        next_overflowFlag = 1'b0;
                    end
                    if (wdata[`TCOU_FLAG_CMP] && !(match && !ctrl.waveModeSelect[0])) begin
                        next_compareFlag = 1'b0;
                    end
                end
                `TCOU_OFF_PORT: begin
                    next_port.portOut         = wdata[`TCOU_PORT_OUT];
                    next_port.pinDirectionBit = wdata[`TCOU_PORT_DIR];
                end
                default: next_port = port;
            endcase
        end
        if (doWrite && wordOk && wstrb[1] && waddr == `TCOU_OFF_CTRL) begin
            next_ctrl.tickDivide = wdata[`TCOU_CTRL_DIV_HI:`TCOU_CTRL_DIV_LO];
        end
        // Interrupt acknowledges from the core clear flags unless set now
        if (overflowAck && !(tick && counterValue == `TCOU_COUNT_MAX)) begin
            next_overflowFlag = 1'b0;
        end
        if (compareAck && !(match && !ctrl.waveModeSelect[0])) begin
            next_compareFlag = 1'b0;
        end
    end

    // Read channel: one register per aligned word, unmapped reads give an error
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `TCOU_RESP_OKAY;
            case (s_axi_araddr)
                `TCOU_OFF_CTRL: next_rdata = {16'h0000, ctrl.tickDivide, 3'h0,
                    ctrl.outputActionSelect, ctrl.waveModeSelect, ctrl.tickEnable};
                `TCOU_OFF_COUNT:   next_rdata = {24'h000000, counterValue};
                `TCOU_OFF_COMPARE: next_rdata = {24'h000000, compareValue};
                `TCOU_OFF_FLAGS:   next_rdata = {30'h00000000, compareFlag, overflowFlag};
                `TCOU_OFF_PORT:    next_rdata = {29'h00000000, compareOutputState,
                    port.pinDirectionBit, port.portOut};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `TCOU_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl               <= '0;
            port               <= '0;
            counterValue       <= `TCOU_RST_BYTE;
            compareValue       <= `TCOU_RST_BYTE;
            compareOutputState <= `TCOU_RST_STATE;
            overflowFlag       <= 1'b0;
            compareFlag        <= 1'b0;
            blockNext          <= 1'b0;
            wstate             <= TCOU_WR_IDLE;
            waddr              <= 12'h000;
            wdata              <= 32'h00000000;
            wstrb              <= 4'h0;
            haveAw             <= 1'b0;
            haveW              <= 1'b0;
            s_axi_rvalid       <= 1'b0;
            s_axi_rdata        <= 32'h00000000;
            s_axi_rresp        <= `TCOU_RESP_OKAY;
        end else begin
            ctrl               <= next_ctrl;
            port               <= next_port;
            counterValue       <= next_counterValue;
            compareValue       <= next_compareValue;
            compareOutputState <= next_compareOutputState;
            overflowFlag       <= next_overflowFlag;
            compareFlag        <= next_compareFlag;
            blockNext          <= next_blockNext;
            wstate             <= next_wstate;
            waddr              <= next_waddr;
            wdata              <= next_wdata;
            wstrb              <= next_wstrb;
            haveAw             <= next_haveAw;
            haveW              <= next_haveW;
            s_axi_rvalid       <= next_rvalid;
            s_axi_rdata        <= next_rdata;
            s_axi_rresp        <= next_rresp;
        end
    end

    // Checks
    property p_block_after_write;
        @(posedge clk) disable iff (!arst_n) wrCount |=> blockNext;
    endproperty
    a_block_after_write : assert property (p_block_after_write)
        else $error("counter write did not arm the block");
    property p_no_match_after_write;
        @(posedge clk) disable iff (!arst_n) blockNext && tick && !forceStrobe
            |=> $stable(compareOutputState);
    endproperty
    a_no_match_after_write : assert property (p_no_match_after_write)
        else $error("match during block window");
    property p_write_wins;
        @(posedge clk) disable iff (!arst_n) wrCount |=> counterValue == $past(wdata[7:0]);
    endproperty
    a_write_wins : assert property (p_write_wins)
        else $error("counter write lost");
    property p_idle_hold;
        @(posedge clk) disable iff (!arst_n) !tick && !wrCount
            |=> counterValue == $past(counterValue);
    endproperty
    a_idle_hold : assert property (p_idle_hold)
        else $error("counter moved without tick");
    property p_ovf_set;
        @(posedge clk) disable iff (!arst_n) tick && !wrCount && counterValue == 8'hFF
            |=> overflowFlag && counterValue == 8'h00;
    endproperty
    a_ovf_set : assert property (p_ovf_set)
        else $error("overflow not set at wrap");
    property p_ctc_clear;
        @(posedge clk) disable iff (!arst_n) tick && !wrCount && ctrl.waveModeSelect == 2'h2
            && counterValue == compareValue |=> counterValue == 8'h00;
    endproperty
    a_ctc_clear : assert property (p_ctc_clear)
        else $error("clear on match missed");
    property p_cmp_flag;
        @(posedge clk) disable iff (!arst_n) match && !ctrl.waveModeSelect[0] |=> compareFlag;
    endproperty
    a_cmp_flag : assert property (p_cmp_flag)
        else $error("compare flag not set");
    property p_none_keeps;
        @(posedge clk) disable iff (!arst_n) (match || forceStrobe)
            && actSel == TCOU_ACT_NONE |=> $stable(compareOutputState);
    endproperty
    a_none_keeps : assert property (p_none_keeps)
        else $error("state changed with action none");
    property p_force_toggle;
        @(posedge clk) disable iff (!arst_n) forceStrobe && !match
            && actSel == TCOU_ACT_TOGGLE
            |=> compareOutputState != $past(compareOutputState) && $stable(compareFlag);
    endproperty
    a_force_toggle : assert property (p_force_toggle)
        else $error("force did not toggle");
    c_wrap  : cover property (@(posedge clk) disable iff (!arst_n) tick && counterValue == 8'hFF);
    c_match : cover property (@(posedge clk) disable iff (!arst_n) match);
    c_force : cover property (@(posedge clk) disable iff (!arst_n) forceStrobe);
endmodule

// ---- testbench/tcou_pin_model.sv ----
// Pad of the general port pin with its pull-up
`timescale 1ns/1ps

module tcou_pin_model (
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      pad
);
    // Released pad floats to the pull-up level, never to the last value
    assign pad = pinOe ? pinOut : 1'b1;
endmodule

// ---- testbench/tcou_top_tb.sv ----
// Self-checking bench of the timer compare output unit
`timescale 1ns/1ps
`include "tcou_defines.svh"

module tcou_top_tb;
    import tcou_pkg::*;
    logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready, ovfAck, cmpAck;
    logic        awready, wready, bvalid, arready, rvalid, pinOut, pinOe, pad, s;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    int          errTotal, testsRun;

    tcou_top u_tcou_top (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .overflowAck(ovfAck),
        .compareAck(cmpAck), .pinOut(pinOut), .pinOe(pinOe));
    tcou_pin_model u_tcou_pin_model (.pinOut(pinOut), .pinOe(pinOe), .pad(pad));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Readies are looked at mid-cycle so the edge itself never races them
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            if (awready) pa = 1'b0;
            if (wready) pw = 1'b0;
            @(posedge clk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
        end
        do begin
            @(negedge clk);
            rsp = bresp;
        end while (bvalid !== 1'b1);
        // Ready stays up so a following call never drives it twice in one step
        @(posedge clk);
    endtask

    task automatic rdw(input logic [11:0] a);
        logic p;
        p = 1'b1;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (p) begin
            @(negedge clk);
            if (arready) p = 1'b0;
            @(posedge clk);
            if (!p) arvalid <= 1'b0;
        end
        do begin
            @(negedge clk);
            rd = rdata;
            rsp = rresp;
        end while (rvalid !== 1'b1);
        @(posedge clk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        rdw(a);
        cmp(rd & m, e);
    endtask

    // Pin is registered, so give it two edges before looking
    task automatic pchk(input logic eo, input logic ep);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp({31'h0, pinOe}, {31'h0, eo});
        cmp({31'h0, pad}, {31'h0, ep});
        @(posedge clk);
    endtask

    function automatic logic [31:0] ctl(logic en, logic [1:0] md, tcou_action_t ac,
                                        logic fc, logic [7:0] dv);
        return {16'h0, dv, 2'h0, fc, ac, md, en};
    endfunction

    task automatic pulse(input logic ov);
        if (ov) ovfAck <= 1'b1;
        else cmpAck <= 1'b1;
        @(posedge clk);
        ovfAck <= 1'b0;
        cmpAck <= 1'b0;
    endtask

    task automatic t_reset;
        rchk(`TCOU_OFF_PORT, 32'h0, 32'h4);
        rchk(`TCOU_OFF_COUNT, 32'h0, 32'hFF);
    endtask

    task automatic t_force;
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_SET, 1'b1, 8'h0));
        rchk(`TCOU_OFF_PORT, 32'h4, 32'h4);
        rchk(`TCOU_OFF_FLAGS, 32'h0, 32'h3);
        rchk(`TCOU_OFF_COUNT, 32'h0, 32'hFF);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_CLEAR, 1'b1, 8'h0));
        rchk(`TCOU_OFF_PORT, 32'h0, 32'h4);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_TOGGLE, 1'b1, 8'h0));
        rchk(`TCOU_OFF_PORT, 32'h4, 32'h4);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h2, TCOU_ACT_NONE, 1'b1, 8'h0));
        rchk(`TCOU_OFF_PORT, 32'h4, 32'h4);
    endtask

    // State is already set, only now the direction goes to output
    task automatic t_pin;
        wr(`TCOU_OFF_PORT, 32'h2);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h2, TCOU_ACT_SET, 1'b0, 8'h0));
        pchk(1'b1, 1'b1);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_NONE, 1'b0, 8'h0));
        pchk(1'b1, 1'b0);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_SET, 1'b0, 8'h0));
        wr(`TCOU_OFF_PORT, 32'h0);
        pchk(1'b0, 1'b1);
    endtask

    task automatic t_ctc;
        wr(`TCOU_OFF_COMPARE, 32'h3);
        wr(`TCOU_OFF_COUNT, 32'h0);
        wr(`TCOU_OFF_FLAGS, 32'h3);
        wr(`TCOU_OFF_CTRL, ctl(1'b1, 2'h2, TCOU_ACT_TOGGLE, 1'b0, 8'h0));
        repeat (20) @(posedge clk);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h2, TCOU_ACT_TOGGLE, 1'b0, 8'h0));
        rdw(`TCOU_OFF_COUNT);
        cmp({31'h0, rd <= 32'h3}, 32'h1);
        rchk(`TCOU_OFF_FLAGS, 32'h2, 32'h3);
        pulse(1'b0);
        rchk(`TCOU_OFF_FLAGS, 32'h0, 32'h3);
    endtask

    task automatic t_normal;
        wr(`TCOU_OFF_COMPARE, 32'h80);
        wr(`TCOU_OFF_COUNT, 32'hFE);
        wr(`TCOU_OFF_CTRL, ctl(1'b1, 2'h0, TCOU_ACT_NONE, 1'b0, 8'h0));
        repeat (10) @(posedge clk);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_NONE, 1'b0, 8'h0));
        rdw(`TCOU_OFF_COUNT);
        cmp({31'h0, rd < 32'h40}, 32'h1);
        rchk(`TCOU_OFF_FLAGS, 32'h1, 32'h3);
        pulse(1'b1);
        rchk(`TCOU_OFF_FLAGS, 32'h0, 32'h3);
    endtask

    // Counter written equal to compare must not toggle; a later real match must
    task automatic t_block;
        rdw(`TCOU_OFF_PORT);
        s = rd[2];
        wr(`TCOU_OFF_COMPARE, 32'h5);
        wr(`TCOU_OFF_COUNT, 32'h5);
        wr(`TCOU_OFF_CTRL, ctl(1'b1, 2'h0, TCOU_ACT_TOGGLE, 1'b0, 8'h0));
        repeat (4) @(posedge clk);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_TOGGLE, 1'b0, 8'h0));
        rchk(`TCOU_OFF_PORT, {29'h0, s, 2'h0}, 32'h4);
        rchk(`TCOU_OFF_FLAGS, 32'h0, 32'h2);
        wr(`TCOU_OFF_COUNT, 32'h4);
        wr(`TCOU_OFF_CTRL, ctl(1'b1, 2'h0, TCOU_ACT_TOGGLE, 1'b0, 8'h0));
        repeat (4) @(posedge clk);
        wr(`TCOU_OFF_CTRL, ctl(1'b0, 2'h0, TCOU_ACT_NONE, 1'b0, 8'h0));
        rchk(`TCOU_OFF_PORT, {29'h0, ~s, 2'h0}, 32'h4);
        rchk(`TCOU_OFF_FLAGS, 32'h2, 32'h2);
    endtask

    task automatic t_bad;
        wr(12'h014, 32'h1);
        cmp({30'h0, rsp}, {30'h0, `TCOU_RESP_SLVERR});
        rdw(12'h020);
        cmp({30'h0, rsp}, {30'h0, `TCOU_RESP_SLVERR});
        cmp(rd, 32'h0);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole sequence needs a few hundred cycles, so this is generous
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        complete_run;
    end

    initial begin
        arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; ovfAck = 1'b0; cmpAck = 1'b0; awaddr = '0; araddr = '0;
        wdata = '0; errTotal = 0; testsRun = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_force;
        t_pin;
        t_ctc;
        t_normal;
        t_block;
        t_bad;
        complete_run;
    end
endmodule
